//--- design/timer2_modes_clock_out.sv
// Second timer/counter: auto-reload, capture, baud-rate ticks and 50% clock-out.
// Assumes control bytes come from software-held logic on clk_in, which is the oscillator clock.
//
// What this block does
// R1: With internal trigger control, reload happens only on overflow and no capture happens.
// R2: With external control, trigger pin falling edge also captures or reloads, unless baud mode.
// R3: Control value selects baud use: 34H/36H both, 24H/26H receive, 14H/16H transmit.
// R4: Clock-out drives a clock with equal high and low times onto the pin.
// R5: The same pin also serves as the external count clock input.
// R6: Software clears counter select and sets clock-out enable to get clock-out.
// R7: The timer counts only while run bit, control bit 2, is set.
// R8: Clock-out frequency derives from oscillator and the 16-bit reload value.
// R9: Divider factor is 2 in six-clock mode and 4 in twelve-clock mode.
// R10: Output frequency is oscillator over factor times (65536 minus reload).
// R11: In clock-out mode rollovers raise no timer interrupt flag.
// R12: Baud generation and clock-out may run together from one reload value.
`timescale 1ns/1ps
`include "timer2_defs.svh"

module timer2_modes_clock_out #(
	parameter int COUNT_WIDTH = 16
) (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic [7:0] timer2_control_reg_in,
	input wire logic clock_out_enable_in,
	input wire logic six_clock_mode_in,
	input wire logic reload_write_in,
	input wire logic [15:0] reload_value_in,
	input wire logic flags_clear_in,
	input wire logic external_trigger_pin_in,
	input wire logic count_pin_in,
	output logic count_pin_out,
	output logic count_pin_oe_n_out,
	output logic [15:0] count_out,
	output logic [15:0] reload_capture_out,
	output logic overflow_flag_out,
	output logic trigger_flag_out,
	output logic rx_baud_tick_out,
	output logic tx_baud_tick_out,
	output timer2_pkg::count_mode_t mode_out
);
	import timer2_pkg::*;

	// The reload arithmetic is fixed at sixteen bits, so any other width is refused when the design is built.
	if (COUNT_WIDTH != 16) begin : g_width_check
		$error("COUNT_WIDTH must be 16");
	end

	// ************************************************
	// Control decode and input edges
	// ************************************************
	logic [7:0] ctrl_reg;
	logic clkout_en_reg;
	logic six_reg;
	logic baud_active;
	logic clkout_active;
	logic trig_level;
	logic trig_prev_reg;
	logic pin_level;
	logic pin_prev_reg;
	logic trig_fall;
	logic pin_fall;
	logic [3:0] prescale_reg;
	logic [3:0] prescale_limit;
	logic tick;
	logic ovf;
	logic ext_event;
	count_mode_t mode_next;

	pin_filter #(
		.RESET_LEVEL(1'b1)
	) trig_filter (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.pin_in(external_trigger_pin_in),
		.level_out(trig_level)
	);

	pin_filter #(
		.RESET_LEVEL(1'b1)
	) count_filter (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.pin_in(count_pin_in),
		.level_out(pin_level)
	);

	// Control copies are registered so every mode decision comes from one sample.
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			ctrl_reg <= `CTRL_RST;
			clkout_en_reg <= 1'b0;
			six_reg <= 1'b0;
			trig_prev_reg <= 1'b1;
			pin_prev_reg <= 1'b1;
		end else begin
			ctrl_reg <= timer2_control_reg_in;
			clkout_en_reg <= clock_out_enable_in;
			six_reg <= six_clock_mode_in;
			trig_prev_reg <= trig_level;
			pin_prev_reg <= pin_level;
		end
	end

	assign trig_fall = trig_prev_reg & ~trig_level;
	assign pin_fall = pin_prev_reg & ~pin_level;
	// R3: baud selection bits
	assign baud_active = ctrl_reg[`T2_BIT_RX_CLOCK] | ctrl_reg[`T2_BIT_TX_CLOCK];
	// R6: clock-out needs timer select
	assign clkout_active = clkout_en_reg & ~ctrl_reg[`T2_BIT_COUNTER];

	// R7: run bit gates counting
	always_comb begin
		if (!ctrl_reg[`T2_BIT_RUN]) begin
			mode_next = MODE_STOP;
		end else if (ctrl_reg[`T2_BIT_COUNTER]) begin
			mode_next = MODE_COUNTER;
		end else if (baud_active || clkout_active) begin
			mode_next = MODE_FAST;
		end else begin
			mode_next = MODE_TIMER;
		end
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			mode_out <= MODE_STOP;
		end else begin
			mode_out <= mode_next;
		end
	end

	// ************************************************
	// Prescaler
	// ************************************************
	// R9: fast modes step every one or two clocks
	always_comb begin
		case (mode_out)
			MODE_FAST: prescale_limit = six_reg ? `FAST_DIV_SIX : `FAST_DIV_TWELVE;
			MODE_TIMER: prescale_limit = six_reg ? `MC_DIV_SIX : `MC_DIV_TWELVE;
			default: prescale_limit = `PRESCALE_ONE;
		endcase
	end

	// The prescaler restarts whenever counting stops so the first period is whole.
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			prescale_reg <= `PRESCALE_RST;
		end else if (mode_out == MODE_STOP || mode_out == MODE_COUNTER) begin
			prescale_reg <= `PRESCALE_RST;
		end else if (prescale_reg >= prescale_limit - `PRESCALE_ONE) begin
			prescale_reg <= `PRESCALE_RST;
		end else begin
			prescale_reg <= prescale_reg + `PRESCALE_ONE;
		end
	end

	// R5: pin edges clock counter mode
	always_comb begin
		case (mode_out)
			MODE_COUNTER: tick = pin_fall;
			MODE_TIMER: tick = (prescale_reg >= prescale_limit - `PRESCALE_ONE);
			MODE_FAST: tick = (prescale_reg >= prescale_limit - `PRESCALE_ONE);
			default: tick = 1'b0;
		endcase
	end

	assign ovf = tick & (count_out == `COUNT_MAX);
	// R2: trigger pin acts outside baud
	assign ext_event = ctrl_reg[`T2_BIT_EXT_ENABLE] & trig_fall & ~baud_active;

	// ************************************************
	// Count and reload/capture registers
	// ************************************************
	// R1: reload only on overflow
	// R8: reload from 16-bit value
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			count_out <= `COUNT_RST;
		end else if (ovf && (mode_out == MODE_FAST || !ctrl_reg[`T2_BIT_CAPTURE])) begin
			count_out <= reload_capture_out;
		end else if (ext_event && !ctrl_reg[`T2_BIT_CAPTURE]) begin
			count_out <= reload_capture_out;
		end else if (tick) begin
			count_out <= count_out + `COUNT_ONE;
		end
	end

	// A capture wins over a software write in the same cycle so no event is lost.
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			reload_capture_out <= `COUNT_RST;
		end else if (ext_event && ctrl_reg[`T2_BIT_CAPTURE]) begin
			reload_capture_out <= count_out;
		end else if (reload_write_in) begin
			reload_capture_out <= reload_value_in;
		end
	end

	// ************************************************
	// Flags and baud ticks
	// ************************************************
	// R11: no overflow flag when fast
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			overflow_flag_out <= 1'b0;
			trigger_flag_out <= 1'b0;
		end else begin
			// Mode lags the control copy by one cycle, so the fast-mode term keeps a late rollover quiet.
			if (ovf && !baud_active && !clkout_active && mode_out != MODE_FAST) begin
				overflow_flag_out <= 1'b1;
			end else if (flags_clear_in) begin
				overflow_flag_out <= 1'b0;
			end
			if (ext_event) begin
				trigger_flag_out <= 1'b1;
			end else if (flags_clear_in) begin
				trigger_flag_out <= 1'b0;
			end
		end
	end

	// R12: ticks share the overflow
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			rx_baud_tick_out <= 1'b0;
			tx_baud_tick_out <= 1'b0;
		end else begin
			rx_baud_tick_out <= ovf & ctrl_reg[`T2_BIT_RX_CLOCK];
			tx_baud_tick_out <= ovf & ctrl_reg[`T2_BIT_TX_CLOCK];
		end
	end

	// ************************************************
	// Clock-out pin
	// ************************************************
	// R4: toggle per overflow
	// R10: half period is one rollover
	// Toggling on every overflow gives equal high and low times by construction.
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			count_pin_out <= 1'b1;
			count_pin_oe_n_out <= 1'b1;
		end else begin
			count_pin_oe_n_out <= ~clkout_active;
			if (!clkout_active) begin
				count_pin_out <= 1'b1;
			end else if (ovf) begin
				count_pin_out <= ~count_pin_out;
			end
		end
	end

	// ************************************************
	// Checks
	// ************************************************
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);

	internal_trigger_only_a: assert property ($rose(trigger_flag_out) |-> $past(ctrl_reg[`T2_BIT_EXT_ENABLE])) // R1
		else $error("trigger flag set with internal control");
	pin_capture_a: assert property ((ext_event && ctrl_reg[`T2_BIT_CAPTURE]) |=> // R2
		reload_capture_out == $past(count_out))
		else $error("trigger edge did not capture count");
	baud_ignores_pin_a: assert property ((trig_fall && baud_active) |=> !$rose(trigger_flag_out)) // R2
		else $error("trigger pin acted in baud mode");
	rx_tick_cause_a: assert property (rx_baud_tick_out |-> $past(ovf && ctrl_reg[`T2_BIT_RX_CLOCK])) // R3
		else $error("receive tick without overflow");
	clock_toggle_a: assert property (($changed(count_pin_out) && $past(clkout_active)) |-> $past(ovf)) // R4
		else $error("clock-out changed without overflow");
	pin_counter_a: assert property ((mode_out == MODE_COUNTER && !pin_fall && !trig_fall && !ovf) // R5
		|=> $stable(count_out))
		else $error("counter moved without pin edge");
	run_gate_a: assert property ((mode_out == MODE_STOP && !ext_event) |=> $stable(count_out)) // R7
		else $error("count moved while stopped");
	fast_reload_a: assert property ((ovf && mode_out == MODE_FAST) |=> count_out == $past(reload_capture_out)) // R8
		else $error("fast overflow did not reload");
	twelve_rate_a: assert property ((tick && mode_out == MODE_FAST && mode_next == MODE_FAST && !six_reg // R9
		&& !six_clock_mode_in) |=> !tick)
		else $error("twelve-clock fast mode stepped twice running");
	no_fast_flag_a: assert property ((ovf && mode_out == MODE_FAST) |=> !$rose(overflow_flag_out)) // R11
		else $error("overflow flag raised in fast mode");
	joint_use_a: assert property ((ovf && clkout_active && ctrl_reg[`T2_BIT_RX_CLOCK]) // R12
		|=> rx_baud_tick_out && $changed(count_pin_out))
		else $error("baud and clock-out not both driven");

endmodule : timer2_modes_clock_out

//--- design/timer2_defs.svh
// Constants for the second timer/counter: control bit positions, prescale counts and reset values.
// Assumes inclusion by design files only; holds definitions and nothing else.
`ifndef TIMER2_DEFS_SVH
`define TIMER2_DEFS_SVH

// ************************************************
// Control register bit positions
// ************************************************
`define T2_BIT_CAPTURE 0
`define T2_BIT_COUNTER 1
`define T2_BIT_RUN 2
`define T2_BIT_EXT_ENABLE 3
`define T2_BIT_TX_CLOCK 4
`define T2_BIT_RX_CLOCK 5

// ************************************************
// Prescale counts and reset values
// ************************************************
`define MC_DIV_SIX 4'h6
`define MC_DIV_TWELVE 4'hC
`define FAST_DIV_SIX 4'h1
`define FAST_DIV_TWELVE 4'h2
`define PRESCALE_ONE 4'h1
`define PRESCALE_RST 4'h0
`define COUNT_RST 16'h0000
`define COUNT_MAX 16'hFFFF
`define COUNT_ONE 16'h0001
`define CTRL_RST 8'h00

`endif

//--- design/timer2_pkg.sv
// Types shared by the second timer/counter design files.
// Assumes the constants header is compiled alongside.
package timer2_pkg;

	// ************************************************
	// Counting source, one-hot
	// ************************************************
	typedef enum logic [3:0] {
		MODE_STOP = 4'b0001,
		MODE_TIMER = 4'b0010,
		MODE_COUNTER = 4'b0100,
		MODE_FAST = 4'b1000
	} count_mode_t;

endpackage : timer2_pkg

//--- design/pin_filter.sv
// Three-stage pin synchroniser with agreement filter.
// Assumes an asynchronous pin input and one clock domain.
`timescale 1ns/1ps

module pin_filter #(
	parameter logic RESET_LEVEL = 1'b1
) (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic pin_in,
	output logic level_out
);

	logic meta_reg;
	logic sync_reg;
	logic agree_reg;

	// The first stage feeds the second only; the filter looks at stages two and three.
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			meta_reg <= RESET_LEVEL;
			sync_reg <= RESET_LEVEL;
			agree_reg <= RESET_LEVEL;
		end else begin
			meta_reg <= pin_in;
			sync_reg <= meta_reg;
			agree_reg <= sync_reg;
		end
	end

	// A change is taken only once two consecutive samples agree.
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			level_out <= RESET_LEVEL;
		end else if (sync_reg == agree_reg) begin
			level_out <= agree_reg;
		end
	end

endmodule : pin_filter

//--- testbench/pin_partner.sv
// Far-side model: drives the external trigger pin and the count pin.
// Assumes one clock; the count pin is pulled up and the timer wins while it drives.
`timescale 1ns/1ps

module pin_partner (
	input wire logic clk_in,
	input wire logic pin_level_in,
	input wire logic pin_oe_n_in,
	output logic trigger_pin_out,
	output wire logic count_pin_out
);
	logic trigger_level_reg = 1'b1;
	logic count_level_reg = 1'b1;

	assign count_pin_out = pin_oe_n_in ? count_level_reg : pin_level_in;
	assign trigger_pin_out = trigger_level_reg;

	// falling pulse
	// Each level is held eight cycles so the input filter sees agreement.
	task pulse(input logic on_trigger);
		@(negedge clk_in);
		if (on_trigger) trigger_level_reg = 1'b0;
		else count_level_reg = 1'b0;
		repeat (8) @(negedge clk_in);
		trigger_level_reg = 1'b1;
		count_level_reg = 1'b1;
		repeat (8) @(negedge clk_in);
	endtask : pulse
endmodule : pin_partner

//--- testbench/timer2_modes_clock_out_test.sv
// Self-checking bench for the second timer/counter.
// Assumes the pin partner model; inputs change on the falling edge.
`timescale 1ns/1ps

module timer2_modes_clock_out_test;
	import timer2_pkg::*;
	logic clk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic [7:0] ctrl = 8'h00;
	logic clk_en = 1'b0, six = 1'b0, rl_wr = 1'b0, fl_clr = 1'b0;
	logic [15:0] rl_val = 16'h0000, c0, r;
	wire logic trig_pin, cnt_pin;
	logic pin_out, oe_n, ovf, trg, rxt, txt, s;
	logic [15:0] cnt, rcap;
	count_mode_t mode;
	int err_count = 0, n_compared = 0, cycles = 0, seed = 32'h89b5, rx_n, tx_n, hi, lo, i;
	logic [7:0] baud_codes [6] = '{8'h34, 8'h24, 8'h14, 8'h36, 8'h26, 8'h16};

	timer2_modes_clock_out u_timer2_modes_clock_out (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
		.timer2_control_reg_in(ctrl), .clock_out_enable_in(clk_en), .six_clock_mode_in(six),
		.reload_write_in(rl_wr), .reload_value_in(rl_val), .flags_clear_in(fl_clr),
		.external_trigger_pin_in(trig_pin), .count_pin_in(cnt_pin), .count_pin_out(pin_out),
		.count_pin_oe_n_out(oe_n), .count_out(cnt), .reload_capture_out(rcap),
		.overflow_flag_out(ovf), .trigger_flag_out(trg), .rx_baud_tick_out(rxt),
		.tx_baud_tick_out(txt), .mode_out(mode));
	pin_partner u_pin_partner (.clk_in(clk_in), .pin_level_in(pin_out), .pin_oe_n_in(oe_n),
		.trigger_pin_out(trig_pin), .count_pin_out(cnt_pin));

	// ************************************************
	// Clock, watchdog and shared tasks
	// ************************************************
	// Free-running oscillator clock, 25 ns period.
	initial forever #12.5 clk_in = ~clk_in;

	// The ceiling sits well above the longest expected run so a hang cannot pass.
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 60000) begin
			err_count++;
			results();
		end
	end

	task check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	// Loads reload, control and flag clear together, then lets the mode settle.
	task setup(input logic [7:0] c, input logic e, input logic sx, input logic [15:0] rv);
		@(negedge clk_in);
		ctrl = c;
		clk_en = e;
		six = sx;
		rl_val = rv;
		rl_wr = 1'b1;
		fl_clr = 1'b1;
		@(negedge clk_in);
		rl_wr = 1'b0;
		fl_clr = 1'b0;
		repeat (4) @(negedge clk_in);
	endtask : setup

	// Ticks stand one cycle, so one sample per falling edge sees each once.
	task watch(input int n);
		rx_n = 0;
		tx_n = 0;
		repeat (n) begin
			@(negedge clk_in);
			rx_n += int'(rxt === 1'b1);
			tx_n += int'(txt === 1'b1);
		end
	endtask : watch

	// Measures one high and one low stretch of the pin, starting at an edge.
	task halves();
		logic p;
		int k;
		p = pin_out;
		for (k = 0; k < 3000 && pin_out === p; k++) @(negedge clk_in);
		repeat (2) begin
			p = pin_out;
			k = 0;
			while (pin_out === p && k < 3000) begin
				@(negedge clk_in);
				k++;
			end
			if (p) hi = k;
			else lo = k;
		end
	endtask : halves

	function int half_exp(input logic sx, input logic [15:0] rv);
		return (sx ? 1 : 2) * (65536 - int'(rv));
	endfunction : half_exp

	task results();
		$display("counts: compared=%0d mismatches=%0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : results

	// ************************************************
	// Main sequence
	// ************************************************
	// Tests run in order; once the first enabled trigger pulse reloads it, each leaves the count near the top for the next.
	initial begin
		repeat (10) @(negedge clk_in);
		sys_rst_in = 1'b0;
		check(mode, MODE_STOP);
		check({pin_out, oe_n, ovf, trg}, 4'hC);
		setup(8'h00, 1'b0, 1'b0, 16'hFF00);
		c0 = cnt;
		watch(60);
		check(cnt, c0);
		$display("test stop done");
		setup(8'h04, 1'b0, 1'b0, 16'hFF00);
		check(mode, MODE_TIMER);
		u_pin_partner.pulse(1'b1);
		check(trg, 1'b0);
		check(cnt[15:8] === 8'hFF, 1'b0);
		setup(8'h0C, 1'b0, 1'b0, 16'hFF00);
		u_pin_partner.pulse(1'b1);
		check(trg, 1'b1);
		check(cnt[15:8], 8'hFF);
		watch(3300);
		check(ovf, 1'b1);
		check(cnt[15:8], 8'hFF);
		setup(8'h0D, 1'b0, 1'b0, 16'h1234);
		u_pin_partner.pulse(1'b1);
		check(trg, 1'b1);
		check(rcap[15:8], 8'hFF);
		$display("test trigger done");
		// Baud mode with the trigger enabled and an internal clock: the pin must be ignored.
		setup(8'h3C, 1'b0, 1'b0, 16'hFFF0);
		watch(600);
		u_pin_partner.pulse(1'b1);
		check(trg, 1'b0);
		for (i = 0; i < 6; i++) begin
			// External codes count pin falls; reload FFFF makes every fall after the first rollover a tick.
			setup(baud_codes[i], 1'b0, 1'b1, baud_codes[i][1] ? 16'hFFFF : 16'hFFF0);
			if (baud_codes[i][1]) begin
				fork
					watch(360);
					repeat (20) u_pin_partner.pulse(1'b0);
				join
				lo = 5;
				hi = 20;
			end else begin
				watch(160);
				lo = 9;
				hi = 11;
			end
			check(rx_n >= lo && rx_n <= hi, baud_codes[i][5]);
			check(tx_n >= lo && tx_n <= hi, baud_codes[i][4]);
			check(ovf, 1'b0);
		end
		$display("test baud done");
		for (i = 0; i < 4; i++) begin
			r = 16'hFFC0 | (16'($random(seed)) & 16'h003E);
			s = 1'($random(seed));
			if (i < 2) s = i[0];
			setup(8'h04, 1'b1, s, r);
			halves();
			check(16'(hi), 16'(half_exp(s, r)));
			check(16'(lo), 16'(hi));
			check(oe_n, 1'b0);
			check(ovf, 1'b0);
		end
		setup(8'h06, 1'b1, 1'b0, 16'hFFF0);
		watch(100);
		check({oe_n, pin_out}, 2'b11);
		$display("test clock-out done");
		// The count may start as low as FFC0, below the reload, so the pin edge is found before ticks are counted.
		setup(8'h34, 1'b1, 1'b1, 16'hFFF8);
		halves();
		check(16'(hi), 16'h0008);
		watch(64);
		check(rx_n >= 7 && rx_n <= 9, 1'b1);
		$display("test shared done");
		setup(8'h06, 1'b0, 1'b0, 16'h0000);
		c0 = cnt;
		repeat (3) u_pin_partner.pulse(1'b0);
		check(cnt, c0 + 16'h0003);
		check(mode, MODE_COUNTER);
		$display("test counter done");
		results();
	end
endmodule : timer2_modes_clock_out_test
